// >>> include/sys_clock_map.svh
`ifndef SYS_CLOCK_MAP_SVH
`define SYS_CLOCK_MAP_SVH

`define SCK_OFS_STATUS    12'h050
`define SCK_OFS_RUN       12'h060
`define SCK_OFS_RUN_EXT   12'h070
`define SCK_OFS_GATE      12'h100
`define SCK_OFS_DSLEEP    12'h144

`define SCK_EXT_USE_BIT   31
`define SCK_EXT_HALF_BIT  30
`define SCK_EXT_DIV_HI    28
`define SCK_EXT_DIV_LO    23
`define SCK_EXT_LSB_BIT   22
`define SCK_RUN_DIV_HI    26
`define SCK_RUN_DIV_LO    23
`define SCK_RUN_USEDIV    22
`define SCK_PWRDN_BIT     13
`define SCK_BYPASS_BIT    11
`define SCK_CRYSTAL_SELECT_HI       10
`define SCK_CRYSTAL_SELECT_LO       6

`define SCK_RUN_RESET     32'h0780_2AC0
`define SCK_EXT_RESET     32'h0780_2800
`define SCK_DS_RESET      32'h0780_0800
`define SCK_RUN_MASK      32'h07C0_2FC0
`define SCK_EXT_MASK      32'hDFC0_2800
`define SCK_DS_MASK       32'h1F80_0800

`define SCK_LOCK_COUNT    14'h1200
`define SCK_LOCK_COUNT_HI 14'h2400
`define SCK_CRYSTAL_SELECT_HI_LIM   5'h0F

`define SCK_VCO_MHZ       400
`define SCK_PLL_PREDIV    2
`define SCK_ADC_MHZ       16

`endif

// >>> include/sys_clock_pkg.sv
package sys_clock_pkg;

  typedef enum logic [1:0] {
    SRC_OSC     = 2'b00,
    SRC_PLLHALF = 2'b01,
    SRC_PLLRAW  = 2'b10
  } src_t;

endpackage

// >>> hdl/system_clock_divider_select.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "sys_clock_map.svh"

module system_clock_divider_select
  import sys_clock_pkg::*;
#(
  parameter int          NPERIPH      = 8,
  parameter logic [13:0] LOCK_COUNT   = `SCK_LOCK_COUNT,
  parameter logic [13:0] LOCK_COUNT_HI = `SCK_LOCK_COUNT_HI
) (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic               oscClkIn,
  input  wire logic               pllTick,
  input  wire logic               deepSleep,
  output logic                    sysClkTick,
  output logic [NPERIPH-1:0]      periphClkTick,
  output logic                    adcClkTick,
  output logic                    pllLocked
);

  localparam logic [7:0] ADC_STEP = 8'(`SCK_ADC_MHZ);
  localparam logic [7:0] ADC_WRAP = 8'(`SCK_VCO_MHZ / `SCK_PLL_PREDIV);

  typedef struct packed {
    logic               oscSync1;
    logic               oscSync2;
    logic               oscPrev;
    logic [31:0]        runCfg;
    logic [31:0]        runCfgExt;
    logic [31:0]        dsCfg;
    logic [NPERIPH-1:0] gate;
    logic [13:0]        lockCnt;
    logic               pwrdnPrev;
    logic               preDiv;
    logic [7:0]         divCnt;
    logic [7:0]         curDiv;
    src_t               curSrc;
    logic               sysTick;
    logic [NPERIPH-1:0] periphTick;
    logic [7:0]         adcAcc;
    logic               adcTick;
    logic [31:0]        rdata;
    logic               rerr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic        extOn;
  logic        halfOn;
  logic        bypassEff;
  logic        pwrdnEff;
  logic        locked;
  logic [7:0]  effDiv;
  src_t        effSrc;
  logic        oscEdge;
  logic        pllHalfTick;
  logic        srcTick;
  logic        setup;
  logic        wrEn;
  logic [4:0]  xtalNew;
  logic [31:0] statusWord;

  assign pready        = 1'b1;
  assign prdata        = s_r.rdata;
  assign pslverr       = s_r.rerr & psel & penable;
  assign sysClkTick    = s_r.sysTick;
  assign periphClkTick = s_r.periphTick;
  assign adcClkTick    = s_r.adcTick;
  assign pllLocked     = locked;

  assign setup   = psel & ~penable;
  assign wrEn    = psel & penable & pwrite;
  assign oscEdge = s_r.oscSync2 & ~s_r.oscPrev;

  // Effective configuration, chosen combinationally from the registers.
  always_comb begin
    extOn     = s_r.runCfgExt[`SCK_EXT_USE_BIT];
    halfOn    = extOn & s_r.runCfgExt[`SCK_EXT_HALF_BIT];
    pwrdnEff  = extOn ? s_r.runCfgExt[`SCK_PWRDN_BIT]
                      : s_r.runCfg[`SCK_PWRDN_BIT];
    locked    = (s_r.lockCnt == 14'h0000) & ~pwrdnEff;
    bypassEff = s_r.runCfg[`SCK_BYPASS_BIT];
    effDiv    = 8'h01;
    if (deepSleep) begin
      bypassEff = s_r.dsCfg[`SCK_BYPASS_BIT];
      effDiv    = {2'b00, s_r.dsCfg[`SCK_EXT_DIV_HI:`SCK_EXT_DIV_LO]}
                  + 8'h01;
    end else if (halfOn) begin
      bypassEff = s_r.runCfgExt[`SCK_BYPASS_BIT];
      effDiv    = {1'b0, s_r.runCfgExt[`SCK_EXT_DIV_HI:`SCK_EXT_DIV_LO],
                   s_r.runCfgExt[`SCK_EXT_LSB_BIT]} + 8'h01;
    end else if (extOn) begin
      bypassEff = s_r.runCfgExt[`SCK_BYPASS_BIT];
      effDiv    = {2'b00, s_r.runCfgExt[`SCK_EXT_DIV_HI:`SCK_EXT_DIV_LO]}
                  + 8'h01;
    end else if (s_r.runCfg[`SCK_RUN_USEDIV] |
                 ~s_r.runCfg[`SCK_BYPASS_BIT]) begin
      effDiv    = {4'h0, s_r.runCfg[`SCK_RUN_DIV_HI:`SCK_RUN_DIV_LO]}
                  + 8'h01;
    end else begin
      effDiv    = 8'h01;
    end
    // The oscillator keeps clocking until the PLL has locked.
    if (bypassEff | ~locked) begin
      effSrc = SRC_OSC;
    end else if (halfOn & ~deepSleep) begin
      effSrc = SRC_PLLRAW;
    end else begin
      effSrc = SRC_PLLHALF;
    end
  end

  assign pllHalfTick = pllTick & s_r.preDiv;

  always_comb begin
    unique case (s_r.curSrc)
      SRC_OSC:     srcTick = oscEdge;
      SRC_PLLHALF: srcTick = pllHalfTick;
      SRC_PLLRAW:  srcTick = pllTick;
      default:     srcTick = oscEdge;
    endcase
  end

  always_comb begin
    statusWord        = 32'h0000_0000;
    statusWord[0]     = locked;
    statusWord[1]     = (s_r.curSrc != SRC_OSC);
    statusWord[15:8]  = s_r.curDiv;
    statusWord[17:16] = s_r.curSrc;
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.oscSync1 = oscClkIn;
    s_nxt.oscSync2 = s_r.oscSync1;
    s_nxt.oscPrev  = s_r.oscSync2;
    s_nxt.sysTick  = 1'b0;
    s_nxt.adcTick  = 1'b0;
    xtalNew        = s_r.runCfg[`SCK_CRYSTAL_SELECT_HI:`SCK_CRYSTAL_SELECT_LO];

    // Register writes take effect in the access phase.
    if (wrEn) begin
      unique case (paddr)
        `SCK_OFS_RUN: begin
          s_nxt.runCfg = pwdata & `SCK_RUN_MASK;
          xtalNew      = pwdata[`SCK_CRYSTAL_SELECT_HI:`SCK_CRYSTAL_SELECT_LO];
        end
        `SCK_OFS_RUN_EXT: s_nxt.runCfgExt = pwdata & `SCK_EXT_MASK;
        `SCK_OFS_DSLEEP:  s_nxt.dsCfg     = pwdata & `SCK_DS_MASK;
        `SCK_OFS_GATE:    s_nxt.gate      = pwdata[NPERIPH-1:0];
        default: begin
        end
      endcase
    end

    // Read data and error are captured in the setup phase.
    if (setup) begin
      s_nxt.rerr  = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        `SCK_OFS_RUN:     s_nxt.rdata = s_r.runCfg;
        `SCK_OFS_RUN_EXT: s_nxt.rdata = s_r.runCfgExt;
        `SCK_OFS_DSLEEP:  s_nxt.rdata = s_r.dsCfg;
        `SCK_OFS_GATE:    s_nxt.rdata[NPERIPH-1:0] = s_r.gate;
        `SCK_OFS_STATUS:  s_nxt.rdata = statusWord;
        default:          s_nxt.rerr  = 1'b1;
      endcase
    end

    // Lock counter: reload on crystal change or power-up, else count down.
    s_nxt.pwrdnPrev = pwrdnEff;
    if ((xtalNew != s_r.runCfg[`SCK_CRYSTAL_SELECT_HI:`SCK_CRYSTAL_SELECT_LO]) |
        (s_r.pwrdnPrev & ~pwrdnEff)) begin
      s_nxt.lockCnt = (xtalNew > `SCK_CRYSTAL_SELECT_HI_LIM) ? LOCK_COUNT_HI
                                                   : LOCK_COUNT;
    end else if (oscEdge & (s_r.lockCnt != 14'h0000)) begin
      s_nxt.lockCnt = s_r.lockCnt - 14'h0001;
    end

    if (pllTick) begin
      s_nxt.preDiv = ~s_r.preDiv;
    end

    // A new divisor or source is taken only when a period completes.
    if (srcTick) begin
      if (s_r.divCnt >= s_r.curDiv - 8'h01) begin
        s_nxt.divCnt  = 8'h00;
        s_nxt.sysTick = 1'b1;
        s_nxt.curDiv  = effDiv;
        s_nxt.curSrc  = effSrc;
      end else begin
        s_nxt.divCnt  = s_r.divCnt + 8'h01;
      end
    end
    s_nxt.periphTick = s_nxt.sysTick ? s_r.gate
                                     : {NPERIPH{1'b0}};

    // Converter clock from the predivided PLL, fractional to 16 MHz.
    if (pllHalfTick & locked) begin
      if (s_r.adcAcc + ADC_STEP >= ADC_WRAP) begin
        s_nxt.adcAcc  = s_r.adcAcc + ADC_STEP - ADC_WRAP;
        s_nxt.adcTick = 1'b1;
      end else begin
        s_nxt.adcAcc  = s_r.adcAcc + ADC_STEP;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r.oscSync1   <= 1'b0;
      s_r.oscSync2   <= 1'b0;
      s_r.oscPrev    <= 1'b0;
      s_r.runCfg     <= `SCK_RUN_RESET;
      s_r.runCfgExt  <= `SCK_EXT_RESET;
      s_r.dsCfg      <= `SCK_DS_RESET;
      s_r.gate       <= {NPERIPH{1'b0}};
      s_r.lockCnt    <= 14'h0000;
      s_r.pwrdnPrev  <= 1'b1;
      s_r.preDiv     <= 1'b0;
      s_r.divCnt     <= 8'h00;
      s_r.curDiv     <= 8'h01;
      s_r.curSrc     <= SRC_OSC;
      s_r.sysTick    <= 1'b0;
      s_r.periphTick <= {NPERIPH{1'b0}};
      s_r.adcAcc     <= 8'h00;
      s_r.adcTick    <= 1'b0;
      s_r.rdata      <= 32'h0000_0000;
      s_r.rerr       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// >>> testbench/sys_clock_asserts.sv
`timescale 1ns/1ps
`include "sys_clock_map.svh"
module sys_clock_asserts #(
  parameter int          NPERIPH    = 8,
  parameter logic [13:0] LOCK_COUNT = 14'h0010
) (
  input wire logic               clock,
  input wire logic               resetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic               oscClkIn,
  input wire logic               pllTick,
  input wire logic               deepSleep,
  input wire logic               sysClkTick,
  input wire logic [NPERIPH-1:0] periphClkTick,
  input wire logic               adcClkTick,
  input wire logic               pllLocked
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic        oscQ_r;
  logic [15:0] edges_r;
  // Raw oscillator edges since reset bound the design's synced count.
  always_ff @(posedge clock) begin
    oscQ_r <= oscClkIn;
    if (!resetn) edges_r <= '0;
    else if (oscClkIn && !oscQ_r && edges_r != '1) edges_r <= edges_r + 1;
  end
  ready_always_a: assert property (pready) else $error("pready low");
  periph_gated_a: assert property (|periphClkTick |-> sysClkTick)
    else $error("peripheral tick without system tick");
  sys_pulse_a: assert property (sysClkTick |=> !sysClkTick)
    else $error("system tick longer than one cycle");
  adc_locked_a: assert property (adcClkTick |-> $past(pllLocked))
    else $error("converter tick without lock");
  adc_pulse_a: assert property (adcClkTick |=> !adcClkTick)
    else $error("converter tick too long");
  err_unmapped_a: assert property (pslverr |-> psel && penable &&
    !(paddr inside {12'h050, 12'h060, 12'h070, 12'h100, 12'h144}))
    else $error("slave error on mapped access");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
    !sysClkTick && !pllLocked && !adcClkTick && !pslverr)
    else $error("outputs active after reset");
  lock_wait_a: assert property (pllLocked |-> edges_r >= LOCK_COUNT)
    else $error("lock before count expired");
  cover property (sysClkTick && |periphClkTick);
  cover property ($rose(pllLocked));
  cover property (pslverr);
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "sys_clock_map.svh"
module tb;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pllTick, deepSleep, sysClkTick, adcClkTick;
  logic        oscClkIn = 1'b0;
  logic        pllLocked;
  logic [7:0]  periphClkTick;
  logic [1:0]  oc = 2'b00;
  logic [32:0] q[$];
  int          err_total, checked, cyc, n;
  system_clock_divider_select #(.LOCK_COUNT(14'h0010),
    .LOCK_COUNT_HI(14'h0020)) i_system_clock_divider_select (.clock,
    .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .oscClkIn, .pllTick, .deepSleep, .sysClkTick,
    .periphClkTick, .adcClkTick, .pllLocked);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    oc <= oc + 1;
    oscClkIn <= oc[1];
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata}, q.pop_front());
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input [31:0] v);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (!pready);
    psel <= 0; penable <= 0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic meas(input string nm, input int e);
    int c;
    repeat (3) begin
      c = 0;
      do begin @(posedge clock); c++; end while (!sysClkTick);
    end
    check(nm, c, e);
  endtask
  function automatic logic [31:0] rc(logic [3:0] dv, logic u, p, b);
    return {5'h0, dv, u, 8'h0, p, 1'b0, b, 5'h0B, 6'h0};
  endfunction
  function automatic logic [31:0] ec(logic h, logic [5:0] dv, logic l, b);
    return {1'b1, h, 1'b0, dv, l, 10'h0, b, 11'h0};
  endfunction
  logic [31:0] ecfg[6] = '{ec(0,9,0,0), ec(0,63,0,0), ec(1,3,1,0),
                           ec(1,4,0,0), ec(0,4,1,0), ec(0,2,0,1)};
  int          eper[6] = '{20, 128, 8, 9, 10, 12};
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    deepSleep = 1'b0;
    pllTick = 1;
    void'($urandom(21));
    repeat (5) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    rd(`SCK_OFS_RUN, {1'b0, `SCK_RUN_RESET});
    rd(`SCK_OFS_RUN_EXT, {1'b0, `SCK_EXT_RESET});
    rd(`SCK_OFS_DSLEEP, {1'b0, `SCK_DS_RESET});
    rd(`SCK_OFS_GATE, 33'h0);
    apb(1, 12'h200, 32'hFFFF_FFFF);
    rd(12'h200, {1'b1, 32'h0});
    // The PLL stays powered down so no reserved PLL divisor can take effect.
    d = $urandom | 32'h0000_2000;
    apb(1, `SCK_OFS_RUN, d);
    rd(`SCK_OFS_RUN, {1'b0, d & `SCK_RUN_MASK});
    $display("register test done");
    apb(1, `SCK_OFS_RUN, rc(2, 1, 1, 1));
    meas("osc div3", 12);
    apb(1, `SCK_OFS_RUN, rc(5, 0, 1, 1));
    meas("osc undivided", 4);
    apb(1, `SCK_OFS_RUN, rc(3, 1, 0, 0));
    while (!pllLocked) @(posedge clock);
    meas("pll div4", 8);
    rd(`SCK_OFS_STATUS, {1'b0, 32'h0001_0403});
    $display("legacy test done");
    apb(1, `SCK_OFS_DSLEEP, {3'h0, 6'd2, 11'h0, 1'b1, 11'h0});
    deepSleep <= 1;
    meas("deep sleep", 12);
    deepSleep <= 0;
    d = $urandom % 256;
    apb(1, `SCK_OFS_GATE, d);
    do @(posedge clock); while (!sysClkTick);
    check("gates", periphClkTick, d[7:0]);
    n = 0;
    repeat (4000) begin @(posedge clock); n += adcClkTick; end
    check("adc rate", n inside {[159:161]}, 1);
    $display("tree test done");
    for (int i = 0; i < 6; i++) begin
      apb(1, `SCK_OFS_RUN_EXT, ecfg[i]);
      meas("ext", eper[i]);
    end
    apb(1, `SCK_OFS_RUN_EXT, 32'h0000_0000);
    meas("no override", 8);
    // Crystal 0x10 reloads the long count: 32 edges of 4 cycles each.
    apb(1, `SCK_OFS_RUN, 32'h01C0_0400);
    n = 0;
    while (!pllLocked) begin
      @(posedge clock);
      n++;
    end
    check("lock high crystal_select", n inside {[120:136]}, 1);
    $display("override test done");
    tally_and_finish;
  end
endmodule
bind system_clock_divider_select sys_clock_asserts #(.NPERIPH(NPERIPH),
  .LOCK_COUNT(LOCK_COUNT)) i_sys_clock_asserts (.clock, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .oscClkIn, .pllTick, .deepSleep, .sysClkTick, .periphClkTick,
  .adcClkTick, .pllLocked);
